// >>> design/acs_consts.svh
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define ACS_REG_CTRL 8'h00
`define ACS_REG_STATUS 8'h04
`define ACS_REG_INT_STAT 8'h08
`define ACS_REG_INT_MASK 8'h0c
`define ACS_REG_LAST_SAMPLE 8'h10
`define ACS_REG_CORR_BASE 8'h20

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ACS_CTRL_START_BIT 0
`define ACS_STATUS_DONE_BIT 0
`define ACS_STATUS_BUSY_BIT 1
`define ACS_STATUS_OE_BIT 2
`define ACS_STATUS_SEL_LSB 4
`define ACS_INT_CAL_DONE_BIT 0
`define ACS_INT_CAL_START_BIT 1
`define ACS_INT_OVER_RANGE_BIT 2
`define ACS_INT_BITS 3

// ---------------------------------------------------------------
// reset values and sizes
// ---------------------------------------------------------------
`define ACS_INT_MASK_RST 3'h0
`define ACS_SAMPLE_W 14
`define ACS_CORR_W 16
`define ACS_CORR_N 4
`define ACS_LATENCY 4
`define ACS_CAL_AVG_DEF 2048
`define ACS_SAT_POS 17'sh01fff
`define ACS_SAT_NEG -17'sh02000

`endif

// >>> design/acs_pkg.sv
package acs_pkg;
  typedef logic [31:0] acs_word_t;
  typedef logic [13:0] acs_sample_t;
  typedef logic [15:0] acs_corr_t;
  typedef logic [1:0] acs_htrans_t;
  typedef enum logic {ACS_NORMAL, ACS_CAL} acs_mode_e;
endpackage : acs_pkg

// >>> design/acs_sync.sv
`timescale 1ns/10ps
`default_nettype none

module acs_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } acs_sync_s;

  acs_sync_s q;
  acs_sync_s next_q;

  initial begin
    if (WIDTH < 1) $error("acs_sync: WIDTH must be at least 1");
  end

  always_comb begin
    next_q.meta = i_async;
    next_q.stable = q.meta;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign o_sync = q.stable;
endmodule : acs_sync

`default_nettype wire

// >>> design/acs_clk_div.sv
`timescale 1ns/10ps
`default_nettype none

module acs_clk_div #(
  parameter int DIVIDE = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // sampling enable, one cycle in DIVIDE
  output logic o_tick
);
  localparam int CW = (DIVIDE > 2) ? $clog2(DIVIDE) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } acs_div_s;

  acs_div_s q;
  acs_div_s next_q;

  initial begin
    if (DIVIDE < 2) $error("acs_clk_div: DIVIDE must be at least 2");
  end

  // edge-count divide, so input duty cycle does not matter
  always_comb begin
    next_q = q;
    next_q.tick = (q.cnt == LAST);
    next_q.cnt = (q.cnt == LAST) ? '0 : q.cnt + CW'(1);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign o_tick = q.tick;
endmodule : acs_clk_div

`default_nettype wire

// >>> design/acs_adc_calibration_sequencer.sv
// How it works
// - the request may be asynchronous and is retimed before use.
// - calibration done falls 2 to 3 clocks after a seen request.
// - done high means normal conversion and valid samples.
// - the analog input codes are ignored during calibration.
// - measured corrections are stored and applied until recalibration.
// - sampling runs from a divide-by-two of the input clock.
// - samples leave as 14-bit two's complement, clamped to full scale.
// - each sample appears four sampling periods after it is taken.
// - output enable low floats the sample and over-range pins.
// - calibration done reads 0 while calibrating, 1 otherwise.
//
// Our own choices: register access over AHB-Lite and the address map.
`include "acs_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module acs_adc_calibration_sequencer #(
  parameter int CAL_AVG = `ACS_CAL_AVG_DEF
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire acs_pkg::acs_htrans_t i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire acs_pkg::acs_word_t i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output acs_pkg::acs_word_t o_hrdata,
  // calibration handshake
  input wire logic i_calibration_request,
  output logic o_cal_done,
  // front end: raw offset-binary code and residue measurement
  input wire acs_pkg::acs_sample_t i_raw_code,
  input wire logic i_raw_over_range,
  input wire acs_pkg::acs_corr_t i_cal_measure,
  output logic [1:0] o_cal_stage_sel,
  // sample output pins
  input wire logic i_output_enable,
  output acs_pkg::acs_sample_t o_sample_word,
  output logic o_sample_word_oe,
  output logic o_over_range_flag,
  output logic o_over_range_flag_oe,
  output logic o_sample_valid_strobe,
  // interrupt
  output logic o_irq
);
  import acs_pkg::*;

  localparam int AVG_W = $clog2(CAL_AVG);
  // one register per sampling period of latency
  localparam int PIPE_N = `ACS_LATENCY;
  localparam logic [AVG_W-1:0] AVG_LAST = AVG_W'(CAL_AVG - 1);
  localparam logic [1:0] LAST_STAGE = 2'(`ACS_CORR_N - 1);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  initial begin
    if (CAL_AVG < 2)
      $error("acs: CAL_AVG must be at least 2");
    if ((CAL_AVG & (CAL_AVG - 1)) != 0)
      $error("acs: CAL_AVG must be a power of two");
    // the sum must fit the 32-bit accumulator
    if (AVG_W > 15)
      $error("acs: CAL_AVG must not exceed 32768");
    // stage index and correction select are two bits wide
    if (`ACS_CORR_N != 4)
      $error("acs: exactly four correction entries are served");
    if (PIPE_N < 1)
      $error("acs: pipeline latency must be at least 1");
  end

  typedef struct packed {
    // calibration
    acs_mode_e mode;
    logic req_prev;
    logic [1:0] cal_idx;
    logic [AVG_W-1:0] avg_cnt;
    logic signed [31:0] acc;
    logic [`ACS_CORR_N-1:0][`ACS_CORR_W-1:0] corr;
    // sample pipeline and pins
    logic [PIPE_N-1:0][`ACS_SAMPLE_W-1:0] pipe;
    logic [PIPE_N-1:0] pipe_or;
    logic [PIPE_N-1:0] pipe_vld;
    logic [`ACS_SAMPLE_W-1:0] sample_word;
    logic over_range;
    logic strobe;
    logic oe;
    // calibration handshake
    logic done;
    // bus data phase
    logic dph_valid;
    logic dph_write;
    logic [7:0] dph_addr;
    logic [31:0] hrdata;
    // interrupts
    logic [`ACS_INT_BITS-1:0] int_stat;
    logic [`ACS_INT_BITS-1:0] int_mask;
    logic irq;
  } acs_state_s;

  acs_state_s q;
  acs_state_s next_q;

  logic req_sync;
  logic tick;

  // ---------------------------------------------------------------
  // request retiming and sampling clock
  // ---------------------------------------------------------------
  acs_sync #(
    .WIDTH(1)
  ) u_req_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_async(i_calibration_request),
    .o_sync(req_sync)
  );

  acs_clk_div #(
    .DIVIDE(2)
  ) u_clk_div (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .o_tick(tick)
  );

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  function automatic logic [31:0] read_mux(input acs_state_s s,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `ACS_REG_STATUS: begin
        r[`ACS_STATUS_DONE_BIT] = s.done;
        r[`ACS_STATUS_BUSY_BIT] = (s.mode == ACS_CAL);
        r[`ACS_STATUS_OE_BIT] = s.oe;
        r[`ACS_STATUS_SEL_LSB +: 2] = s.cal_idx;
      end
      `ACS_REG_INT_STAT: r[`ACS_INT_BITS-1:0] = s.int_stat;
      `ACS_REG_INT_MASK: r[`ACS_INT_BITS-1:0] = s.int_mask;
      `ACS_REG_LAST_SAMPLE: begin
        r[`ACS_SAMPLE_W-1:0] = s.sample_word;
        r[31] = s.over_range;
      end
      default: begin
        if (a[7:4] == 4'(`ACS_REG_CORR_BASE >> 4)
            && {1'b0, a[3:2]} < 3'(`ACS_CORR_N))
          r[`ACS_CORR_W-1:0] = s.corr[a[3:2]];
      end
    endcase
    return r;
  endfunction : read_mux

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // bus and events
  logic addr_take;
  logic soft_start;
  logic hard_start;
  logic start;
  logic ev_done;
  logic ev_or;
  logic rd_clr;
  // sample conversion
  logic [1:0] corr_sel;
  logic [`ACS_SAMPLE_W-1:0] twos;
  logic signed [16:0] twos_ext;
  logic signed [16:0] corr_ext;
  logic signed [16:0] diff;
  logic [`ACS_SAMPLE_W-1:0] corrected;
  logic corr_or;
  // residue averaging
  logic signed [31:0] acc_sum;
  logic signed [31:0] avg;

  always_comb begin
    next_q = q;
    addr_take = i_hsel && i_htrans[1] && i_hready;
    soft_start = q.dph_valid && q.dph_write
                 && q.dph_addr == `ACS_REG_CTRL
                 && i_hwdata[`ACS_CTRL_START_BIT];
    hard_start = req_sync && !q.req_prev;
    // requests while calibrating are dropped
    start = (hard_start || soft_start) && q.mode == ACS_NORMAL;
    ev_done = 1'b0;
    ev_or = 1'b0;
    rd_clr = addr_take && !i_hwrite && i_haddr == `ACS_REG_INT_STAT;

    // -------------------------------------------------------------
    // sample conversion
    // -------------------------------------------------------------
    // offset binary to two's complement, then mismatch correction
    twos = {~i_raw_code[`ACS_SAMPLE_W-1], i_raw_code[`ACS_SAMPLE_W-2:0]};
    corr_sel = i_raw_code[`ACS_SAMPLE_W-1 -: 2];
    twos_ext = 17'($signed(twos));
    corr_ext = 17'($signed(q.corr[corr_sel]));
    diff = twos_ext - corr_ext;
    corr_or = 1'b0;
    if (diff > `ACS_SAT_POS) begin
      corrected = 14'h1fff;
      corr_or = 1'b1;
    end else if (diff < `ACS_SAT_NEG) begin
      corrected = 14'h2000;
      corr_or = 1'b1;
    end else begin
      corrected = diff[`ACS_SAMPLE_W-1:0];
    end

    // running residue sum, averaged by a shift
    acc_sum = q.acc + 32'($signed(i_cal_measure));
    avg = acc_sum >>> AVG_W;

    next_q.req_prev = req_sync;
    next_q.strobe = 1'b0;
    // drive enable follows the pin one clock late
    next_q.oe = i_output_enable;

    // -------------------------------------------------------------
    // calibration sequence and sample pipeline
    // -------------------------------------------------------------
    case (q.mode)
      ACS_NORMAL: begin
        if (start) begin
          next_q.mode = ACS_CAL;
          next_q.done = 1'b0;
          next_q.cal_idx = 2'h0;
          next_q.avg_cnt = '0;
          next_q.acc = '0;
          next_q.pipe_vld = '0;
        end else if (tick) begin
          next_q.pipe[0] = corrected;
          next_q.pipe_or[0] = i_raw_over_range || corr_or;
          next_q.pipe_vld[0] = 1'b1;
          for (int i = 1; i < PIPE_N; i++) begin
            next_q.pipe[i] = q.pipe[i-1];
            next_q.pipe_or[i] = q.pipe_or[i-1];
            next_q.pipe_vld[i] = q.pipe_vld[i-1];
          end
          if (q.pipe_vld[PIPE_N-1]) begin
            next_q.sample_word = q.pipe[PIPE_N-1];
            next_q.over_range = q.pipe_or[PIPE_N-1];
            next_q.strobe = 1'b1;
            ev_or = q.pipe_or[PIPE_N-1];
          end
        end
      end
      ACS_CAL: begin
        // raw input codes are not looked at here
        if (tick) begin
          next_q.acc = acc_sum;
          next_q.avg_cnt = q.avg_cnt + AVG_W'(1);
          if (q.avg_cnt == AVG_LAST) begin
            next_q.corr[q.cal_idx] = avg[`ACS_CORR_W-1:0];
            next_q.acc = '0;
            next_q.avg_cnt = '0;
            if (q.cal_idx == LAST_STAGE) begin
              next_q.mode = ACS_NORMAL;
              next_q.done = 1'b1;
              ev_done = 1'b1;
            end else begin
              next_q.cal_idx = q.cal_idx + 2'h1;
            end
          end
        end
      end
      default: begin
        next_q.mode = ACS_NORMAL;
        next_q.done = 1'b1;
      end
    endcase

    // -------------------------------------------------------------
    // bus slave
    // -------------------------------------------------------------
    // zero wait states, read data fetched in address phase
    next_q.dph_valid = addr_take;
    if (addr_take) begin
      next_q.dph_write = i_hwrite;
      next_q.dph_addr = i_haddr;
      next_q.hrdata = i_hwrite ? 32'h0000_0000 : read_mux(q, i_haddr);
    end
    if (q.dph_valid && q.dph_write && q.dph_addr == `ACS_REG_INT_MASK)
      next_q.int_mask = i_hwdata[`ACS_INT_BITS-1:0];

    // -------------------------------------------------------------
    // interrupts
    // -------------------------------------------------------------
    // sticky events; a new event wins over the read clear
    next_q.int_stat = (rd_clr ? '0 : q.int_stat)
                      | {ev_or, start, ev_done};
    next_q.irq = |(next_q.int_stat & next_q.int_mask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      // normal mode, zero corrections, no auto-calibration
      q <= '0;
      q.mode <= ACS_NORMAL;
      q.done <= 1'b1;
      q.int_mask <= `ACS_INT_MASK_RST;
    end else begin
      q <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops or tied constants
  // ---------------------------------------------------------------
  // bus
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = q.hrdata;

  // calibration handshake
  assign o_cal_done = q.done;
  assign o_cal_stage_sel = q.cal_idx;

  // sample pins
  assign o_sample_word = q.sample_word;
  assign o_sample_word_oe = q.oe;
  assign o_over_range_flag = q.over_range;
  assign o_over_range_flag_oe = q.oe;
  assign o_sample_valid_strobe = q.strobe;

  // interrupt
  assign o_irq = q.irq;

  // size is not decoded: word transfers only
  logic unused_ok;
  assign unused_ok = ^i_hsize;
endmodule : acs_adc_calibration_sequencer

`default_nettype wire

// >>> test/acs_checker.sv
`timescale 1ns/10ps
`default_nettype none

module acs_checker #(
  parameter int CAL_AVG = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // watched inputs
  input wire logic i_calibration_request,
  input wire logic i_output_enable,
  // watched outputs
  input wire logic o_cal_done,
  input wire acs_pkg::acs_sample_t o_sample_word,
  input wire logic o_sample_word_oe,
  input wire logic o_over_range_flag_oe,
  input wire logic o_sample_valid_strobe
);
  import acs_pkg::*;
  localparam int CAL_MIN = 8 * CAL_AVG - 1;
  localparam int CAL_MAX = 8 * CAL_AVG + 2;
  logic [19:0] low_cnt;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // --------------------------------------------------------------
  // cycles spent calibrating
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= o_cal_done ? 20'h0 : low_cnt + 20'h1;
    end
  end

  sequence s_req_seen;
    $rose(i_calibration_request) ##0 o_cal_done;
  endsequence
  sequence s_done_drop;
    ##[1:4] !o_cal_done;
  endsequence

  a_done_drop: assert property (s_req_seen |-> s_done_drop)
    else $error("done did not drop after request");
  a_done_holds: assert property ($fell(o_cal_done) |-> !o_cal_done [*8])
    else $error("done rose too early");
  a_cal_length: assert property ($rose(o_cal_done) |->
    low_cnt >= CAL_MIN && low_cnt <= CAL_MAX)
    else $error("calibration length wrong");
  a_quiet_cal: assert property (!o_cal_done |-> !o_sample_valid_strobe)
    else $error("sample strobe during calibration");
  a_strobe_rate: assert property (o_sample_valid_strobe |=>
    !o_sample_valid_strobe)
    else $error("strobe faster than half rate");
  a_word_hold: assert property ($changed(o_sample_word) |->
    o_sample_valid_strobe)
    else $error("word changed without strobe");
  a_oe_drive: assert property (1'b1 |=> o_sample_word_oe ==
    $past(i_output_enable) && o_over_range_flag_oe == o_sample_word_oe)
    else $error("output drive does not follow enable");
  a_held_req: assert property (i_calibration_request [*7] ##0 o_cal_done
    |=> o_cal_done)
    else $error("held request restarted calibration");
endmodule : acs_checker

bind acs_adc_calibration_sequencer acs_checker #(.CAL_AVG(CAL_AVG))
  acs_checker_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_calibration_request(i_calibration_request),
  .i_output_enable(i_output_enable), .o_cal_done(o_cal_done),
  .o_sample_word(o_sample_word), .o_sample_word_oe(o_sample_word_oe),
  .o_over_range_flag_oe(o_over_range_flag_oe),
  .o_sample_valid_strobe(o_sample_valid_strobe));

`default_nettype wire

// >>> test/acs_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module acs_host_model (
  // request pulse
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [15:0] i_hold,
  output logic o_req,
  // sample capture
  input wire logic i_done,
  input wire logic i_strobe,
  input wire acs_pkg::acs_sample_t i_word,
  output acs_pkg::acs_sample_t o_word
);
  initial o_req = 1'b0;

  always @(posedge i_go) begin
    #3.3 o_req = 1'b1; // off the clock phase
    repeat (i_hold) @(posedge i_clk); // four clocks or more
    #2.1 o_req = 1'b0;
  end

  always @(posedge i_clk) begin
    if (i_strobe && i_done) begin // only converted samples
      o_word <= i_word;
    end
  end
endmodule : acs_host_model

`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import acs_pkg::*;
  localparam int CAL_AVG = 4;
  logic clk, rst_n, hsel, hwrite, hready, hresp, go, req;
  logic done, oe_in, word_oe, or_oe, orf, strobe, irq, raw_or;
  logic [7:0] haddr;
  logic [1:0] sel;
  logic [15:0] hold;
  acs_htrans_t htrans;
  acs_word_t hwdata, hrdata, v;
  acs_sample_t raw, word, host_word;
  acs_corr_t meas;
  int n, i, n_errors, num_checks;
  acs_sample_t vals [4] = '{14'h3fff, 14'h2000, 14'h0000, 14'h1fff};

  always #4 clk = ~clk; // never paused

  acs_adc_calibration_sequencer #(.CAL_AVG(CAL_AVG))
    acs_adc_calibration_sequencer_inst (.i_clk(clk), .i_arst_n(rst_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_calibration_request(req), .o_cal_done(done),
    .i_raw_code(raw), .i_raw_over_range(raw_or), .i_cal_measure(meas),
    .o_cal_stage_sel(sel), .i_output_enable(oe_in),
    .o_sample_word(word), .o_sample_word_oe(word_oe),
    .o_over_range_flag(orf), .o_over_range_flag_oe(or_oe),
    .o_sample_valid_strobe(strobe), .o_irq(irq));

  acs_host_model acs_host_model_inst (.i_clk(clk), .i_go(go),
    .i_hold(hold), .o_req(req), .i_done(done), .i_strobe(strobe),
    .i_word(word), .o_word(host_word));

  // --------------------------------------------------------------
  // bus and compare helpers
  // --------------------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] a, input acs_word_t d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    v = hrdata;
  endtask : ahb

  task automatic chk(input string s, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input acs_word_t e, input string s);
    ahb(1'b0, a, 32'h0);
    chk(s, e, v);
    chk("hresp", 0, hresp);
  endtask : rd

  task automatic wait_done(input logic lvl);
    n = 0;
    while (done !== lvl) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_done

  task automatic strobes(input int k);
    repeat (k) begin
      do @(posedge clk); while (strobe !== 1'b1);
    end
  endtask : strobes

  task automatic pulse(input logic [15:0] h);
    hold <= h;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : pulse

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    {clk, rst_n, hsel, hwrite, haddr, htrans, hwdata, go} = '0;
    {oe_in, raw_or, raw} = {1'b1, 1'b0, 14'h2000};
    {meas, hold} = {16'h0008, 16'h0004};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk("cal_done", 1, done);
    rd(8'h0c, 32'h0, "int_mask");
    rd(8'h40, 32'h0, "unmapped");
    for (i = 0; i < 4; i++) begin
      raw <= vals[i];
      strobes(6);
      chk("word", {vals[i][13] ^ 1'b1, vals[i][12:0]}, word);
    end
    raw <= 14'h0123;
    n = 0;
    do begin @(posedge clk); n++; end while (word !== 14'h2123 && n < 20);
    chk("latency", 1, n == 10);
    oe_in <= 1'b0;
    repeat (2) @(posedge clk);
    chk("float", 0, word_oe | or_oe);
    oe_in <= 1'b1;
    pulse(16'd4);
    wait_done(1'b0);
    chk("fall", 1, n >= 1 && n <= 5);
    raw <= 14'h0000;
    repeat (10) @(posedge clk);
    raw <= 14'h2000;
    wait_done(1'b1);
    chk("cal_len", 1, n >= 20 && n <= 36);
    rd(8'h08, 32'h3, "int_stat");
    chk("irq_masked", 0, irq);
    rd(8'h08, 32'h0, "int_clear");
    for (i = 0; i < 4; i++)
      rd(8'h20 + 8'(4 * i), 32'h8, "corr");
    strobes(2);
    chk("corrected", 14'h3ff8, word);
    chk("host_word", 14'h3ff8, host_word);
    raw_or <= 1'b1;
    strobes(6);
    chk("raw_or", 1, orf);
    chk("raw_or_word", 14'h3ff8, word);
    raw_or <= 1'b0;
    raw <= 14'h0000;
    strobes(6);
    chk("clamp", 14'h2000, word);
    chk("over_range", 1, orf);
    rd(8'h10, 32'h8000_2000, "last_sample");
    ahb(1'b1, 8'h0c, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    raw <= 14'h2000;
    strobes(6);
    rd(8'h08, 32'h4, "int_or");
    repeat (3) @(posedge clk);
    chk("irq_clear", 0, irq);
    chk("or_clear", 0, orf);
    pulse(16'd60);
    wait_done(1'b0);
    wait_done(1'b1);
    repeat (40) @(posedge clk);
    chk("held", 1, done);
    rd(8'h08, 32'h3, "one_start");
    ahb(1'b1, 8'h00, 32'h1);
    wait_done(1'b0);
    chk("ctrl_start", 1, n <= 4);
    chk("stage_sel", 0, sel);
    rd(8'h04, 32'h6, "status");
    wait_done(1'b1);
    chk("stage_end", 3, sel);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
